// file: hdl/sa_dma_channel.v
`timescale 1ns/1ns
`default_nettype none
`include "sa_dma_defines.vh"

module sa_dma_channel (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        ce,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // activation sources
  input  wire [3:0]  timer_unit_req,
  input  wire        serial_unit_tx_empty,
  input  wire        serial_unit_rx_full,
  input  wire        ext_req,
  // system bus master
  output reg  [23:0] bus_addr,
  output reg         bus_rd,
  output reg         bus_wr,
  output reg         bus_word,
  output reg  [15:0] bus_wdata,
  input  wire [15:0] bus_rdata,
  input  wire        bus_done,
  // completion interrupt level
  output reg         irq
);

  // one-hot sequencer states
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_READ  = 5'h02;
  localparam [4:0] ST_PUSH  = 5'h04;
  localparam [4:0] ST_WRITE = 5'h08;
  localparam [4:0] ST_STEP  = 5'h10;

  // software-visible registers and sequencer state
  reg [23:0] memory_address_r;
  reg [7:0]  fixed_peripheral_address_low_r;
  reg [15:0] transfer_count_r;
  reg [7:0]  transfer_control_register_r;
  reg [4:0]  state_r;
  reg [4:0]  state_nxt;
  reg        rx_dir_r;
  reg        pend_r;
  reg        done_r;
  reg [15:0] ovr_cnt_r;
  reg [15:0] bus_rdata_r;

  // control register fields
  wire transfer_enable_bit   = transfer_control_register_r[`CTL_ENABLE];
  wire completion_irq_enable = transfer_control_register_r[`CTL_IRQ_EN];
  wire size_word             = transfer_control_register_r[`CTL_WORD];
  wire step_down             = transfer_control_register_r[`CTL_DEC];
  wire idle_mode             = transfer_control_register_r[`CTL_IDLE];
  wire [2:0] src_sel = transfer_control_register_r[`CTL_SRC_HI:`CTL_SRC_LO];

  // edge pulses for each of the seven request lines
  wire [6:0] req_lvl = {ext_req, serial_unit_rx_full, serial_unit_tx_empty, timer_unit_req};
  wire [6:0] req_pls;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_req
      req_edge u_edge (
        .mclk  (mclk),
        .rst_b (rst_b),
        .ce    (ce),
        .level (req_lvl[gi]),
        .pulse (req_pls[gi])
      );
    end
  endgenerate

  // selected source; the spare code never fires
  reg src_hit;
  always @* begin
    case (src_sel)
      `SRC_TMR0:     src_hit = req_pls[0];
      `SRC_TMR1:     src_hit = req_pls[1];
      `SRC_TMR2:     src_hit = req_pls[2];
      `SRC_TMR3:     src_hit = req_pls[3];
      `SRC_TX_EMPTY: src_hit = req_pls[4];
      `SRC_RX_FULL:  src_hit = req_pls[5];
      `SRC_EXT:      src_hit = req_pls[6];
      default:       src_hit = 1'b0;
    endcase
  end

  // staging fifo sits between bus read and bus write
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire        fifo_push = (state_r == ST_PUSH);
  wire        fifo_pop  = (state_r == ST_WRITE) && bus_done;

  word_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (bus_rdata_r),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // addresses of the current transfer
  wire [23:0] periph_addr = {`PERIPH_PAGE, fixed_peripheral_address_low_r};

  // direction of a starting transfer comes straight from the source select;
  // the latched copy lags one edge and would reuse the previous job's way
  reg        rx_dir_now;
  reg [23:0] src_addr;
  reg [23:0] dst_addr;
  always @* begin
    rx_dir_now = rx_dir_r;
    if (state_r == ST_IDLE) begin
      rx_dir_now = (src_sel == `SRC_RX_FULL);
    end
    if (rx_dir_now) begin
      src_addr = periph_addr;
      dst_addr = memory_address_r;
    end else begin
      src_addr = memory_address_r;
      dst_addr = periph_addr;
    end
  end

  // memory step: 1 or 2, up or down
  reg [23:0] step_mag;
  reg [23:0] addr_stepped;
  always @* begin
    step_mag = 24'h000001;
    if (size_word) begin
      step_mag = 24'h000002;
    end
    if (step_down) begin
      addr_stepped = memory_address_r - step_mag;
    end else begin
      addr_stepped = memory_address_r + step_mag;
    end
  end

  // count after this transfer; zero start wraps to ffff so 65,536 run
  wire [15:0] count_next = transfer_count_r - 16'h0001;
  wire        last_xfer  = (count_next == 16'h0000);

  // sequencer: read source, stage, write destination, step
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (pend_r && transfer_enable_bit) begin
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        if (bus_done) begin
          state_nxt = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (fifo_in_ready) begin
          state_nxt = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (bus_done) begin
          state_nxt = ST_STEP;
        end
      end
      ST_STEP: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state register and pending request latch
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= ST_IDLE;
      pend_r    <= 1'b0;
      rx_dir_r  <= 1'b0;
      ovr_cnt_r <= 16'h0000;
    end else if (ce) begin
      state_r <= state_nxt;
      // one request held; extra ones while busy are counted, not queued
      if (state_r == ST_IDLE && pend_r && transfer_enable_bit) begin
        pend_r   <= src_hit; // set wins over the take
        rx_dir_r <= (src_sel == `SRC_RX_FULL);
      end else if (src_hit && transfer_enable_bit) begin
        if (pend_r) begin
          ovr_cnt_r <= ovr_cnt_r + 16'h0001;
        end
        pend_r <= 1'b1;
      end else if (!transfer_enable_bit) begin
        pend_r <= 1'b0;
      end
    end
  end

  // bus master outputs, all registered
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bus_addr    <= 24'h000000;
      bus_rd      <= 1'b0;
      bus_wr      <= 1'b0;
      bus_word    <= 1'b0;
      bus_wdata   <= 16'h0000;
      bus_rdata_r <= 16'h0000;
    end else if (ce) begin
      bus_rd   <= (state_nxt == ST_READ);
      bus_wr   <= (state_nxt == ST_WRITE);
      bus_word <= size_word;
      if (state_nxt == ST_READ) begin
        bus_addr <= src_addr;
      end else if (state_nxt == ST_WRITE) begin
        bus_addr  <= dst_addr;
        bus_wdata <= fifo_out_valid ? fifo_out_data : bus_rdata_r;
      end
      if (state_r == ST_READ && bus_done) begin
        bus_rdata_r <= bus_rdata;
      end
    end
  end

  // software registers and the per-transfer bookkeeping
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      memory_address_r               <= `RST_MEM_ADDR;
      fixed_peripheral_address_low_r <= `RST_PERIPH_LOW;
      transfer_count_r               <= `RST_COUNT;
      transfer_control_register_r    <= `RST_CONTROL;
      done_r                         <= 1'b0;
    end else if (ce) begin
      if (reg_wr) begin
        case (reg_addr)
          `OFS_MEM_ADDR: begin
            memory_address_r <= reg_wdata[23:0];
          end
          `OFS_PERIPH_LOW: begin
            fixed_peripheral_address_low_r <= reg_wdata[7:0];
          end
          `OFS_COUNT: begin
            transfer_count_r <= reg_wdata[15:0];
          end
          `OFS_CONTROL: begin
            transfer_control_register_r <= reg_wdata[7:0];
          end
          `OFS_STATUS: begin
            // write one to bit 0 drops the completion flag
            if (reg_wdata[0]) begin
              done_r <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      // transfer finished: step address, count down, maybe end
      if (state_r == ST_STEP) begin
        transfer_count_r <= count_next;
        if (!idle_mode) begin
          memory_address_r <= addr_stepped;
        end // idle mode leaves both addresses alone
        if (last_xfer) begin
          // hardware clear beats a same-cycle software write
          transfer_control_register_r[`CTL_ENABLE] <= 1'b0;
          done_r <= 1'b1; // set wins over the status clear above
        end
      end
    end
  end

  // interrupt level follows the done flag; idle mode always interrupts,
  // I/O mode only when completion interrupts are enabled
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= done_r & (idle_mode | completion_irq_enable);
    end
  end

  // read mux; data appear the cycle after the strobe
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      if (reg_rd) begin
        case (reg_addr)
          `OFS_MEM_ADDR: begin
            reg_rdata <= {8'h00, memory_address_r};
          end
          `OFS_PERIPH_LOW: begin
            reg_rdata <= {24'h000000, fixed_peripheral_address_low_r};
          end
          `OFS_COUNT: begin
            reg_rdata <= {16'h0000, transfer_count_r};
          end
          `OFS_CONTROL: begin
            reg_rdata <= {24'h000000, transfer_control_register_r};
          end
          `OFS_STATUS: begin
            // overrun count, one-hot state, pending and done flags
            reg_rdata <= {ovr_cnt_r, 3'h0, state_r, 6'h00, pend_r, done_r};
          end
          `OFS_RX_DATA: begin
            reg_rdata <= {16'h0000, bus_rdata_r};
          end
          default: begin
            reg_rdata <= 32'h00000000;
          end
        endcase
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

endmodule // sa_dma_channel

`default_nettype wire

// file: include/sa_dma_defines.vh
`ifndef SA_DMA_DEFINES_VH
`define SA_DMA_DEFINES_VH

// register offsets on the plain register port
`define OFS_MEM_ADDR     4'h0
`define OFS_PERIPH_LOW   4'h1
`define OFS_COUNT        4'h2
`define OFS_CONTROL      4'h3
`define OFS_STATUS       4'h4
`define OFS_RX_DATA      4'h5

// control register field positions
`define CTL_ENABLE       0
`define CTL_IRQ_EN       1
`define CTL_WORD         2
`define CTL_DEC          3
`define CTL_IDLE         4
`define CTL_SRC_LO       5
`define CTL_SRC_HI       7

// activation source codes
`define SRC_TMR0         3'h0
`define SRC_TMR1         3'h1
`define SRC_TMR2         3'h2
`define SRC_TMR3         3'h3
`define SRC_TX_EMPTY     3'h4
`define SRC_RX_FULL      3'h5
`define SRC_EXT          3'h6

// reset values
`define RST_MEM_ADDR     24'h000000
`define RST_PERIPH_LOW   8'h00
`define RST_COUNT        16'h0000
`define RST_CONTROL      8'h00

// fixed page for the peripheral address
`define PERIPH_PAGE      16'hffff

// staging fifo shape
`define FIFO_WIDTH       16
`define FIFO_DEPTH       16
`define FIFO_AW          4

`endif

// file: hdl/req_sync.v
`timescale 1ns/1ns
`default_nettype none

// rising-edge detector for a request line, one pulse per edge
module req_edge (
  input  wire mclk,
  input  wire rst_b,
  input  wire ce,
  input  wire level,
  output wire pulse
);

  reg prev_r;

  // remember last level so a held line counts once
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 1'b0;
    end else if (ce) begin
      prev_r <= level;
    end
  end

  assign pulse = level & ~prev_r;

endmodule // req_edge

`default_nettype wire

// file: hdl/word_fifo.v
`timescale 1ns/1ns
`default_nettype none

// small synchronous fifo, valid/ready on both sides
module word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             mclk,
  input  wire             rst_b,
  input  wire             ce,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [AW:0]      fill_r;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (fill_r != DEPTH[AW:0]);
  assign out_valid = (fill_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_r];

  // storage has no reset, only pointers and fill level do
  always @(posedge mclk) begin
    if (ce && push) begin
      mem[wr_r] <= in_data;
    end
  end

  // pointers and fill level
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r   <= {AW{1'b0}};
      rd_r   <= {AW{1'b0}};
      fill_r <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (push && !pop) begin
        fill_r <= fill_r + 1'b1;
      end else if (pop && !push) begin
        fill_r <= fill_r - 1'b1;
      end
    end
  end

endmodule // word_fifo

`default_nettype wire

// file: tb/sa_dma_channel_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "sa_dma_defines.vh"
module sa_dma_channel_chk (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic [23:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic        bus_word,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic        bus_done,
  input wire logic        irq
);
  logic [7:0]  ctl_r;
  logic [15:0] rd_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // shadow of control; only software sets enable, so a clear shadow is trustworthy
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= 8'h00;
      rd_r  <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `OFS_CONTROL) ctl_r <= reg_wdata[7:0];
      if (bus_rd && bus_done) rd_r <= bus_rdata;
    end
  end
  property p_rd_hold; bus_rd && !bus_done |=> bus_rd && $stable(bus_addr); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read request dropped");
  property p_wr_hold; bus_wr && !bus_done |=> bus_wr && $stable(bus_wdata); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write request dropped");
  property p_rd_to_wr; bus_rd && bus_done |=> !bus_rd ##1 bus_wr; endproperty
  a_rd_to_wr: assert property (p_rd_to_wr) else $error("write did not follow read");
  property p_wr_data;
    $rose(bus_wr) |-> (bus_word ? bus_wdata == rd_r : bus_wdata[7:0] == rd_r[7:0]);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not read data");
  property p_periph_dst;
    $rose(bus_wr) && ctl_r[7:5] != `SRC_RX_FULL |-> bus_addr[23:8] == `PERIPH_PAGE;
  endproperty
  a_periph_dst: assert property (p_periph_dst) else $error("bad write page");
  property p_periph_src;
    $rose(bus_rd) && ctl_r[7:5] == `SRC_RX_FULL |-> bus_addr[23:8] == `PERIPH_PAGE;
  endproperty
  a_periph_src: assert property (p_periph_src) else $error("bad read page");
  property p_word; $rose(bus_rd) |-> bus_word == ctl_r[2]; endproperty
  a_word: assert property (p_word) else $error("access size wrong");
  property p_irq_gate; $rose(irq) |-> ctl_r[1] || ctl_r[4]; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not enabled");
  property p_idle_start;
    !ctl_r[0] && $past(ctl_r[0], 4) == 1'b0 |-> !$rose(bus_rd);
  endproperty
  a_idle_start: assert property (p_idle_start) else $error("bus use while off");
  // main traffic kinds
  c_word: cover property (bus_wr && bus_done && bus_word);
  c_rx: cover property ($rose(bus_wr) && ctl_r[7:5] == `SRC_RX_FULL);
  c_irq: cover property ($rose(irq) && ctl_r[4]);
endmodule // sa_dma_channel_chk
bind sa_dma_channel sa_dma_channel_chk sa_dma_channel_chk_i (.mclk, .rst_b, .reg_addr,
  .reg_wdata, .reg_wr, .bus_addr, .bus_rd, .bus_wr, .bus_word, .bus_wdata, .bus_rdata,
  .bus_done, .irq);
`default_nettype wire

// file: tb/bus_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
// memory and peripheral side; read data is a function of the address
module bus_slave_model (
  input  wire logic        mclk,
  input  wire logic [3:0]  lat,
  input  wire logic [23:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [15:0] bus_wdata,
  output var  logic [15:0] bus_rdata,
  output var  logic        bus_done,
  output var  logic [23:0] last_wa,
  output var  logic [15:0] last_wd,
  output var  logic [7:0]  nwr
);
  logic [3:0] cnt = 4'h0;
  logic       seen = 1'b0;
  initial begin
    bus_rdata = 16'h5a5a;
    bus_done = 1'b0;
    nwr = 8'h00;
    last_wa = 24'h000000;
    last_wd = 16'h0000;
  end
  // data lines toggle outside the done cycle so stale data never looks valid
  always @(posedge mclk) begin
    bus_done <= 1'b0;
    bus_rdata <= ~bus_rdata;
    if (!bus_rd && !bus_wr) begin
      seen <= 1'b0;
      cnt <= 4'h0;
    end else if (!seen && cnt >= lat) begin
      bus_done <= 1'b1;
      seen <= 1'b1;
      if (bus_rd) bus_rdata <= bus_addr[15:0] ^ 16'h3c3c;
      if (bus_wr) begin
        last_wa <= bus_addr;
        last_wd <= bus_wdata;
        nwr <= nwr + 8'h01;
      end
    end else if (!seen) cnt <= cnt + 4'h1;
  end
endmodule // bus_slave_model
`default_nettype wire

// file: tb/short_address_dma_channel_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sa_dma_defines.vh"
module short_address_dma_channel_tb_top;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [6:0]  req = 7'h00;
  logic [3:0]  lat = 4'h0;
  logic        ce = 1'b1;
  wire  [31:0] reg_rdata;
  wire  [23:0] bus_addr, last_wa;
  wire  [15:0] bus_wdata, bus_rdata, last_wd;
  wire         bus_rd, bus_wr, bus_word, bus_done, irq;
  wire  [7:0]  nwr;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  sa_dma_channel sa_dma_channel_i (.mclk, .rst_b, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .timer_unit_req(req[3:0]), .serial_unit_tx_empty(req[4]),
    .serial_unit_rx_full(req[5]), .ext_req(req[6]), .bus_addr, .bus_rd, .bus_wr, .bus_word,
    .bus_wdata, .bus_rdata, .bus_done, .irq);
  bus_slave_model bus_slave_model_i (.mclk, .lat, .bus_addr, .bus_rd, .bus_wr, .bus_wdata,
    .bus_rdata, .bus_done, .last_wa, .last_wd, .nwr);
  initial forever #2 mclk = ~mclk;
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, well under a thousand cycles is the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // program, fire n requests, follow each transfer, then check the end state
  task automatic job(input logic [2:0] s, input logic [4:0] c, input int n, input logic [15:0] c0);
    logic [23:0] m, p, a;
    logic [15:0] d;
    logic [31:0] v;
    logic [7:0]  n0;
    int          st;
    m = 24'h012340;
    p = 24'hffff5c;
    st = c[`CTL_WORD] ? 2 : 1;
    if (c[`CTL_DEC]) st = -st;
    wr(`OFS_MEM_ADDR, {8'h00, m});
    wr(`OFS_PERIPH_LOW, 32'h0000005c);
    wr(`OFS_COUNT, {16'h0000, c0});
    wr(`OFS_CONTROL, {24'h000000, s, c});
    for (int k = 0; k < n; k++) begin
      a = c[`CTL_IDLE] ? m : m + 24'(st * k);
      d = (s == `SRC_RX_FULL ? p[15:0] : a[15:0]) ^ 16'h3c3c;
      n0 = nwr;
      @(posedge mclk) req[s] <= 1'b1;
      @(posedge mclk) req[s] <= 1'b0;
      for (int i = 0; i < 60 && nwr == n0; i++) @(posedge mclk);
      repeat (3) @(posedge mclk);
      chk("writes", nwr, n0 + 8'h01);
      chk("wr addr", last_wa, s == `SRC_RX_FULL ? a : p);
      chk("wr data", c[2] ? last_wd : last_wd[7:0], c[2] ? d : d[7:0]);
    end
    rd(`OFS_COUNT, v);
    chk("count", v, {16'h0000, c0 - 16'(n)});
    rd(`OFS_MEM_ADDR, v);
    chk("mem addr", v, {8'h00, c[`CTL_IDLE] ? m : m + 24'(st * n)});
    rd(`OFS_CONTROL, v);
    chk("enable", v[0], c0 != 16'(n));
    chk("irq", irq, c0 == 16'(n) && (c[1] || c[4]));
    rd(`OFS_STATUS, v);
    chk("done", v[0], c0 == 16'(n));
    // clear done while the interrupt enables still stand, so irq must fall by itself
    wr(`OFS_STATUS, 32'h00000001);
    wr(`OFS_CONTROL, {24'h000000, s, 5'h00});
    @(posedge mclk) req[s] <= 1'b1;
    @(posedge mclk) req[s] <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("ignored", nwr, n0 + 8'h01);
    chk("irq clr", irq, 1'b0);
  endtask
  task automatic t_regs;
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      rd(4'(i), v);
      chk("reset val", v, 32'h0);
    end
    // a write while the clock enable is low must leave the register alone
    @(posedge mclk) ce <= 1'b0;
    wr(`OFS_PERIPH_LOW, 32'h000000a5);
    ce <= 1'b1;
    rd(`OFS_PERIPH_LOW, v);
    chk("frozen", v, 32'h0);
    wr(`OFS_MEM_ADDR, 32'hffabcdef);
    wr(4'h7, 32'h12345678);
    rd(`OFS_MEM_ADDR, v);
    chk("mem width", v, 32'h00abcdef);
    @(posedge mclk) #1 chk("rdata drop", reg_rdata, 32'h0);
    rd(4'h7, v);
    chk("unmapped", v, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_sources;
    for (int s = 0; s < 7; s++) begin
      lat <= s[0] ? 4'h0 : 4'h3;
      job(3'(s), {s == 3 || s == 6, s[1], s[0], s[2], 1'b1}, 1, 16'h0001);
    end
    $display("test sources done");
  endtask
  task automatic t_runs;
    lat <= 4'h2;
    job(`SRC_EXT, 5'b01111, 3, 16'h0003);
    job(`SRC_TMR0, 5'b00001, 3, 16'h0003);
    job(`SRC_TX_EMPTY, 5'b10101, 3, 16'h0003);
    job(`SRC_RX_FULL, 5'b00101, 2, 16'h0002);
    job(`SRC_TMR2, 5'b00011, 1, 16'h0000);
    $display("test runs done");
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_sources();
    t_runs();
    end_of_test();
  end
endmodule // short_address_dma_channel_tb_top
`default_nettype wire
